// >>> rtl/lod_pkg.sv
// Constants and types of the bitwise logic datapath.
// Assumes an 8-bit core whose data and peripheral spaces share one address field and are told apart by the io bit.
package lod_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;

	typedef enum logic [1:0] {
		LOP_AND = 2'h0,
		LOP_OR = 2'h1,
		LOP_XOR = 2'h2
	} lod_op_t;

	typedef enum logic [1:0] {
		FORM_A_IMM = 2'h0,
		FORM_A_MEM = 2'h1,
		FORM_MEM_A = 2'h2,
		FORM_IO_A = 2'h3
	} lod_form_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_EXEC = 2'h3,
		ST_WB = 2'h2
	} lod_state_t;

	typedef struct packed {
		lod_op_t op;
		lod_form_t form;
		logic [DATA_W-1:0] imm;
		logic [ADDR_W-1:0] addr;
	} lod_req_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic io;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} lod_dat_out_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
	} lod_dat_in_t;

	typedef struct packed {
		logic result_nil_flag;
		logic borrow_out_flag;
		logic half_carry;
		logic signed_wrap_flag;
	} lod_flags_t;
endpackage : lod_pkg

// >>> rtl/lod_datapath.sv
// Bitwise AND/OR/XOR unit with its working register and flag set.
// Assumes a data space with one-cycle read latency and a one-cycle write.
`timescale 1ns/1ps

// Notes on behaviour
// - AND with an immediate puts working register AND immediate into it.
// - AND with memory into the register reads the byte and ANDs it in.
// - AND into memory writes the ANDed byte back and keeps the register.
// - OR with an immediate puts working register OR immediate into it.
// - OR with memory goes to the register or the byte, as the form says.
// - XOR with an immediate puts working register XOR immediate into it.
// - XOR on a peripheral register reads, XORs and writes it back.
// - Each updates only the zero flag, but the peripheral XOR keeps all.
module lod_datapath (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Request from the decoder
	input wire logic req_valid,
	output logic req_ready,
	input lod_pkg::lod_req_t req,
	output logic done,
	// Data and peripheral space
	output lod_pkg::lod_dat_out_t mem_req,
	input lod_pkg::lod_dat_in_t mem_rsp,
	// Working register and flags, loadable by the rest of the core
	input wire logic wreg_ld,
	input wire logic [lod_pkg::DATA_W-1:0] wreg_ld_val,
	input wire logic flags_ld,
	input lod_pkg::lod_flags_t flags_ld_val,
	output logic [lod_pkg::DATA_W-1:0] working_register,
	output lod_pkg::lod_flags_t flags
);
	lod_pkg::lod_state_t st_r;
	lod_pkg::lod_state_t st_nxt;
	lod_pkg::lod_req_t req_r;
	logic [lod_pkg::DATA_W-1:0] wreg_r;
	logic [lod_pkg::DATA_W-1:0] res_r;
	logic [lod_pkg::DATA_W-1:0] res_nxt;
	lod_pkg::lod_flags_t flags_r;
	lod_pkg::lod_flags_t flags_nxt;

	// Decoding
	wire take = req_valid && req_ready;
	wire req_imm = req.form == lod_pkg::FORM_A_IMM;
	wire imm_form = req_r.form == lod_pkg::FORM_A_IMM;
	wire io_form = req_r.form == lod_pkg::FORM_IO_A;
	wire to_wreg = imm_form || req_r.form == lod_pkg::FORM_A_MEM;
	wire in_rd = st_r == lod_pkg::ST_READ;
	wire in_wb = st_r == lod_pkg::ST_WB;
	wire wreg_wr = in_wb && to_wreg;
	wire mem_wr = in_wb && !to_wreg;
	wire nil_upd = in_wb && !io_form;
	wire [lod_pkg::DATA_W-1:0] opnd_b = imm_form ? req_r.imm :
		mem_rsp.rdata;

	assign req_ready = st_r == lod_pkg::ST_IDLE;
	assign done = in_wb;
	assign working_register = wreg_r;
	assign flags = flags_r;
	assign mem_req = '{rd: in_rd, wr: mem_wr, io: io_form, addr: req_r.addr,
		wdata: res_r};

	// Logic function
	always_comb begin
		res_nxt = lod_pkg::ZERO_BYTE;
		unique case (req_r.op)
			lod_pkg::LOP_AND: res_nxt = wreg_r & opnd_b;
			lod_pkg::LOP_OR: res_nxt = wreg_r | opnd_b;
			lod_pkg::LOP_XOR: res_nxt = wreg_r ^ opnd_b;
			default: res_nxt = lod_pkg::ZERO_BYTE;
		endcase
	end

	// Sequencing
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			lod_pkg::ST_IDLE: begin
				if (take) begin
					st_nxt = req_imm ? lod_pkg::ST_EXEC : lod_pkg::ST_READ;
				end
			end
			lod_pkg::ST_READ: st_nxt = lod_pkg::ST_EXEC;
			lod_pkg::ST_EXEC: st_nxt = lod_pkg::ST_WB;
			lod_pkg::ST_WB: st_nxt = lod_pkg::ST_IDLE;
		endcase
	end

	// Flags: zero flag only, none for peripheral XOR
	always_comb begin
		flags_nxt = flags_r;
		if (in_wb) begin
			if (nil_upd) begin
				flags_nxt.result_nil_flag = res_r == lod_pkg::ZERO_BYTE;
			end
		end else if (flags_ld) begin
			flags_nxt = flags_ld_val;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= lod_pkg::ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_r <= '0;
		end else if (take) begin
			req_r <= req;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			res_r <= lod_pkg::ZERO_BYTE;
		end else if (st_r == lod_pkg::ST_EXEC) begin
			res_r <= res_nxt;
		end
	end

	// Working register, written back only for register forms
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wreg_r <= lod_pkg::WREG_RST;
		end else if (wreg_wr) begin
			wreg_r <= res_r;
		end else if (wreg_ld && req_ready) begin
			wreg_r <= wreg_ld_val;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_r <= lod_pkg::lod_flags_t'(lod_pkg::FLAGS_RST);
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Checks
	wire ex = st_r == lod_pkg::ST_EXEC;
	wire ex_and = ex && req_r.op == lod_pkg::LOP_AND;
	wire ex_or = ex && req_r.op == lod_pkg::LOP_OR;
	wire ex_xor = ex && req_r.op == lod_pkg::LOP_XOR;

	AST_AND_IMM: assert property (@(posedge clk) disable iff (!rst_b)
		ex_and && imm_form |=> ##1
		wreg_r == ($past(wreg_r, 2) & $past(req_r.imm, 2)))
		else $error("AND immediate result wrong");
	AST_AND_MEM_ACC: assert property (@(posedge clk) disable iff (!rst_b)
		ex_and && req_r.form == lod_pkg::FORM_A_MEM |=> ##1
		wreg_r == ($past(wreg_r, 2) & $past(mem_rsp.rdata, 2)))
		else $error("AND memory into register wrong");
	AST_AND_TO_MEM: assert property (@(posedge clk) disable iff (!rst_b)
		ex_and && req_r.form == lod_pkg::FORM_MEM_A |=>
		mem_req.wr && !mem_req.io &&
		mem_req.wdata == ($past(wreg_r) & $past(mem_rsp.rdata)) ##1
		wreg_r == $past(wreg_r, 2))
		else $error("AND into memory wrong");
	AST_OR_IMM: assert property (@(posedge clk) disable iff (!rst_b)
		ex_or && imm_form |=> ##1
		wreg_r == ($past(wreg_r, 2) | $past(req_r.imm, 2)))
		else $error("OR immediate result wrong");
	AST_OR_MEM: assert property (@(posedge clk) disable iff (!rst_b)
		ex_or && (req_r.form == lod_pkg::FORM_A_MEM ||
		req_r.form == lod_pkg::FORM_MEM_A) |=>
		res_r == ($past(wreg_r) | $past(mem_rsp.rdata)) &&
		mem_req.wr == (req_r.form == lod_pkg::FORM_MEM_A))
		else $error("OR memory result wrong");
	AST_OR_MEM_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
		ex_or && req_r.form == lod_pkg::FORM_MEM_A |=> ##1
		wreg_r == $past(wreg_r, 2))
		else $error("OR into memory changed the register");
	AST_XOR_IMM: assert property (@(posedge clk) disable iff (!rst_b)
		ex_xor && imm_form |=> ##1
		wreg_r == ($past(wreg_r, 2) ^ $past(req_r.imm, 2)))
		else $error("XOR immediate result wrong");
	AST_XOR_IO: assert property (@(posedge clk) disable iff (!rst_b)
		ex_xor && req_r.form == lod_pkg::FORM_IO_A |=>
		mem_req.wr && mem_req.io &&
		mem_req.wdata == ($past(wreg_r) ^ $past(mem_rsp.rdata)))
		else $error("XOR peripheral result wrong");
	AST_XOR_IO_READ: assert property (@(posedge clk) disable iff (!rst_b)
		take && req.form == lod_pkg::FORM_IO_A |=> mem_req.rd && mem_req.io)
		else $error("Peripheral register not read");
	AST_XOR_IO_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
		in_wb && io_form |=> wreg_r == $past(wreg_r))
		else $error("Peripheral XOR changed the register");
	AST_READ_STROBE: assert property (@(posedge clk) disable iff (!rst_b)
		take && !req_imm |=> mem_req.rd && mem_req.addr == $past(req.addr))
		else $error("Memory operand not read");
	AST_IMM_NO_ACCESS: assert property (@(posedge clk) disable iff (!rst_b)
		take && req_imm |=> !mem_req.rd ##1 !mem_req.wr && done)
		else $error("Immediate form touched memory");
	AST_WREG_HELD: assert property (@(posedge clk) disable iff (!rst_b)
		!req_ready && !in_wb |=> wreg_r == $past(wreg_r))
		else $error("Working register changed while busy");
	AST_IO_FLAGS_KEPT: assert property (@(posedge clk) disable iff (!rst_b)
		in_wb && io_form |=> flags_r == $past(flags_r))
		else $error("Peripheral XOR changed a flag");
	AST_FLAGS_KEPT: assert property (@(posedge clk) disable iff (!rst_b)
		in_wb |=> flags_r.borrow_out_flag == $past(flags_r.borrow_out_flag)
		&& flags_r.half_carry == $past(flags_r.half_carry)
		&& flags_r.signed_wrap_flag == $past(flags_r.signed_wrap_flag))
		else $error("Carry-type flag changed by logic op");
	AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
		in_wb && !io_form |=> flags_r.result_nil_flag ==
		($past(to_wreg) ? wreg_r == lod_pkg::ZERO_BYTE :
		$past(mem_req.wdata) == lod_pkg::ZERO_BYTE))
		else $error("Zero flag does not match result");

	COV_IMM: cover property (@(posedge clk) disable iff (!rst_b)
		ex_and && imm_form ##2 flags_r.result_nil_flag);
	COV_MEM_WR: cover property (@(posedge clk) disable iff (!rst_b)
		ex_or && req_r.form == lod_pkg::FORM_MEM_A ##1 mem_req.wr);
	COV_IO_XOR: cover property (@(posedge clk) disable iff (!rst_b)
		ex_xor && mem_req.io ##1 mem_req.wr);
	COV_ZERO_MEM: cover property (@(posedge clk) disable iff (!rst_b)
		ex_and && req_r.form == lod_pkg::FORM_MEM_A ##1
		mem_req.wdata == lod_pkg::ZERO_BYTE);
	COV_B2B: cover property (@(posedge clk) disable iff (!rst_b)
		in_wb ##1 take);
endmodule : lod_datapath

// >>> testbench/lod_datapath_tb.sv
// Self-checking bench for the bitwise logic datapath.
// Assumes the bench plays decoder and data space; assertions sit in rtl.
`timescale 1ns/1ps
module lod_datapath_tb;
	logic clk;
	logic rst_b;
	logic req_valid;
	logic req_ready;
	lod_pkg::lod_req_t req;
	logic done;
	lod_pkg::lod_dat_out_t mem_req;
	lod_pkg::lod_dat_in_t mem_rsp;
	logic wreg_ld;
	logic [7:0] wreg_ld_val;
	logic flags_ld;
	lod_pkg::lod_flags_t flags_ld_val;
	logic [7:0] working_register;
	lod_pkg::lod_flags_t flags;
	logic [29:0] notes[$];
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 32'h8aa746e3;

	lod_datapath i_lod_datapath (.clk(clk), .rst_b(rst_b),
		.req_valid(req_valid), .req_ready(req_ready), .req(req),
		.done(done), .mem_req(mem_req), .mem_rsp(mem_rsp),
		.wreg_ld(wreg_ld), .wreg_ld_val(wreg_ld_val), .flags_ld(flags_ld),
		.flags_ld_val(flags_ld_val), .working_register(working_register),
		.flags(flags));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task check(input logic [7:0] seen, input logic [7:0] exp, string m);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s %h not %h", $time, m, seen, exp);
		end
	endtask : check

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task run_op(input logic [1:0] o, f, input logic [7:0] a, b,
		input logic [3:0] fl);
		logic [7:0] res;
		logic [7:0] ad;
		logic mw;
		ad = 8'($random(seed));
		res = (o == 2'h0) ? a & b : (o == 2'h1) ? a | b :
			(o == 2'h2) ? a ^ b : 8'h00;
		mw = (f == 2'h2) || (f == 2'h3);
		for (int n = 0; n < 20 && req_ready !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		wreg_ld = 1'b1;
		wreg_ld_val = a;
		flags_ld = 1'b1;
		flags_ld_val = fl;
		@(posedge clk);
		#1;
		wreg_ld = 1'b0;
		flags_ld = 1'b0;
		req_valid = 1'b1;
		req = {o, f, (f == 2'h0) ? b : ~b, ad};
		notes.push_back({mw, f == 2'h3, ad, res, mw ? a : res,
			(f == 2'h3) ? fl : {res == 8'h00, fl[2:0]}});
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		if (f != 2'h0) begin
			check({7'h0, mem_req.rd}, 8'h01, "read strobe");
			check(mem_req.addr, ad, "read addr");
			@(posedge clk);
			#1;
			mem_rsp.rdata = b;
			@(posedge clk);
			#1;
			mem_rsp.rdata = ~b;
		end
	endtask : run_op

	// Result watcher: pairs each done pulse with the oldest note
	always @(negedge clk) begin
		logic [29:0] n;
		if (rst_b === 1'b1 && done === 1'b1) begin
			check(8'(notes.size() > 0), 8'h01, "note present");
			n = notes.pop_front();
			check({7'h0, mem_req.wr}, {7'h0, n[29]}, "write");
			if (n[29]) begin
				check({7'h0, mem_req.io}, {7'h0, n[28]}, "space");
				check(mem_req.addr, n[27:20], "addr");
				check(mem_req.wdata, n[19:12], "wdata");
			end
			@(negedge clk);
			check(working_register, n[11:4], "wreg");
			check({4'h0, flags}, {4'h0, n[3:0]}, "flags");
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end

	initial begin
		logic [7:0] a;
		logic [7:0] b;
		rst_b = 1'b0;
		req_valid = 1'b0;
		req = '0;
		mem_rsp = '0;
		wreg_ld = 1'b0;
		wreg_ld_val = 8'h00;
		flags_ld = 1'b0;
		flags_ld_val = '0;
		repeat (16) @(posedge clk);
		#1;
		check({7'h0, req_ready}, 8'h01, "ready in reset");
		check({6'h0, done, mem_req.wr}, 8'h00, "strobes in reset");
		check(working_register, 8'h00, "wreg in reset");
		check({4'h0, flags}, 8'h00, "flags in reset");
		rst_b = 1'b1;
		$display("Test reset values done");
		for (int i = 0; i < 48; i++) begin
			a = (i % 5 == 4) ? 8'h00 : 8'($random(seed));
			b = (i % 5 == 4) ? 8'h00 : 8'($random(seed));
			run_op(2'(i % 4), 2'((i / 4) % 4), a, b, 4'($random(seed)));
		end
		repeat (6) @(posedge clk);
		check(8'(notes.size()), 8'h00, "notes left");
		$display("Test logic operations done");
		stop_test();
	end
endmodule : lod_datapath_tb
